// ===== src/cbs_top.sv
// apb register front end, interrupt logic and input synchronisers of the block
// assumes engine and global soft-reset inputs are asynchronous pins
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - bus-off entry sets flag; irq only when masked-in
// - flag clears only on write of one
// - soft reset from global request or config bit
// - soft-reset bit self-clears when reset completes
// - soft reset moves state bus-off to active
// - no bus-off glitch or flag after soft reset
// - pending abort blocks buffer state writes
// - deactivated buffer sent: no flag, no update
module cbs_top (
   input wire logic clk_in,           // 50 MHz peripheral clock
   input wire logic rst_in,           // async reset, high
   input wire logic psel_in,          // apb select
   input wire logic penable_in,       // apb enable
   input wire logic pwrite_in,        // apb direction
   input wire logic [7:0] paddr_in,   // apb byte address
   input wire logic [31:0] pwdata_in, // apb write data
   output logic [31:0] prdata_out,    // apb read data
   output logic pready_out,           // apb ready
   output logic pslverr_out,          // apb error
   input wire logic tx_err_in,        // engine: transmit error pulse
   input wire logic tx_ok_in,         // engine: transmit success pulse
   input wire logic tx_start_in,      // engine: buffer taken for arbitration
   input wire logic tx_won_in,        // engine: buffer sent on bus
   input wire logic glb_soft_rst_in,  // global soft-reset request
   output logic tx_req_out,           // buffer wants the bus
   output logic irq_out               // interrupt, high
);
   cbs_ctl_if c ();
   logic [cbs_pkg::SYN_N-1:0] syn1_q;
   logic [cbs_pkg::SYN_N-1:0] syn2_q;
   logic [cbs_pkg::SYN_N-1:0] syn3_q;
   logic [cbs_pkg::SYN_N-1:0] rise;
   logic [cbs_pkg::NUM_IRQ-1:0] stat_q;
   logic [cbs_pkg::NUM_IRQ-1:0] stat_d;
   logic [cbs_pkg::NUM_IRQ-1:0] mask_q;
   logic [cbs_pkg::NUM_IRQ-1:0] evt;
   logic [cbs_pkg::NUM_IRQ-1:0] w1c;
   logic [31:0] rdata_d;
   logic mapped;
   logic wr_acc;
   logic rd_acc;
   logic irq_q;
   logic tx_req_q;
   logic ready_q;
   logic [31:0] rdata_q;
   logic err_q;

   // two-stage synchronisers, edge taken from the second stage against a third delay stage
   genvar gi;
   generate
      for (gi = 0; gi < cbs_pkg::SYN_N; gi++) begin : g_syn
         always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               syn1_q[gi] <= 1'b0;
               syn2_q[gi] <= 1'b0;
               syn3_q[gi] <= 1'b0;
            end else begin
               syn1_q[gi] <= (gi == cbs_pkg::SYN_ERR) ? tx_err_in :
                             (gi == cbs_pkg::SYN_OK) ? tx_ok_in :
                             (gi == cbs_pkg::SYN_START) ? tx_start_in :
                             (gi == cbs_pkg::SYN_WON) ? tx_won_in : glb_soft_rst_in;
               syn2_q[gi] <= syn1_q[gi];
               syn3_q[gi] <= syn2_q[gi];
            end
         end
         assign rise[gi] = syn2_q[gi] & ~syn3_q[gi];
      end
   endgenerate

   // apb decode; one wait state, access completes in the second access cycle
   assign wr_acc = psel_in && penable_in && ready_q && pwrite_in;
   assign rd_acc = psel_in && penable_in && ready_q && !pwrite_in;

   always_comb begin
      mapped = 1'b1;
      rdata_d = 32'h0000_0000;
      case (paddr_in)
         cbs_pkg::OFF_MODCFG: rdata_d[cbs_pkg::SOFT_RST_BIT] = c.soft_busy;
         cbs_pkg::OFF_ESR: begin
            rdata_d[cbs_pkg::FLT_LSB +: 2] = c.flt;
            rdata_d[cbs_pkg::BOFF_FLAG_BIT] = stat_q[cbs_pkg::IRQ_BOFF];
            rdata_d[cbs_pkg::TEC_LSB +: cbs_pkg::TEC_W] = c.tec;
         end
         cbs_pkg::OFF_IRQ_STAT: rdata_d[cbs_pkg::NUM_IRQ-1:0] = stat_q;
         cbs_pkg::OFF_IRQ_MASK: rdata_d[cbs_pkg::NUM_IRQ-1:0] = mask_q;
         cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER: begin
            rdata_d[3:0] = c.code;
            rdata_d[cbs_pkg::TRANSMIT_MESSAGE_BUFFER_FLAG_BIT] = stat_q[cbs_pkg::IRQ_TXDONE];
         end
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ready_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else begin
         ready_q <= psel_in && penable_in && !ready_q;
         err_q <= psel_in && penable_in && !ready_q && !mapped;
         if (psel_in && penable_in && !ready_q && !pwrite_in) rdata_q <= rdata_d;
      end
   end

   // soft reset from config bit or global request
   assign c.soft_req = (wr_acc && paddr_in == cbs_pkg::OFF_MODCFG && pwdata_in[cbs_pkg::SOFT_RST_BIT])
                       || rise[cbs_pkg::SYN_GSR];
   assign c.err_evt = rise[cbs_pkg::SYN_ERR];
   assign c.ok_evt = rise[cbs_pkg::SYN_OK];
   assign c.start_evt = rise[cbs_pkg::SYN_START];
   assign c.won_evt = rise[cbs_pkg::SYN_WON];
   assign c.code_we = wr_acc && paddr_in == cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER;
   assign c.code_wd = pwdata_in[3:0];

   // sticky status: set wins over a same-cycle clear
   assign evt[cbs_pkg::IRQ_BOFF] = c.boff_evt;
   assign evt[cbs_pkg::IRQ_TXDONE] = c.done_evt;
   assign evt[cbs_pkg::IRQ_SRDONE] = c.sr_done;

   always_comb begin
      w1c = '0;
      if (wr_acc && paddr_in == cbs_pkg::OFF_IRQ_STAT) w1c = pwdata_in[cbs_pkg::NUM_IRQ-1:0];
      if (wr_acc && paddr_in == cbs_pkg::OFF_ESR) w1c[cbs_pkg::IRQ_BOFF] = pwdata_in[cbs_pkg::BOFF_FLAG_BIT];
      if (wr_acc && paddr_in == cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER) w1c[cbs_pkg::IRQ_TXDONE] = pwdata_in[cbs_pkg::TRANSMIT_MESSAGE_BUFFER_FLAG_BIT];
      stat_d = (stat_q & ~w1c) | evt;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) stat_q <= '0;
      else stat_q <= stat_d;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) mask_q <= cbs_pkg::IRQ_MASK_RST;
      else if (wr_acc && paddr_in == cbs_pkg::OFF_IRQ_MASK) mask_q <= pwdata_in[cbs_pkg::NUM_IRQ-1:0];
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_q <= 1'b0;
         tx_req_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
         tx_req_q <= c.tx_req;
      end
   end

   cbs_fcs u_fcs (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .c(c.fcs)
   );

   cbs_transmit_message_buffer u_transmit_message_buffer (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .c(c.txm)
   );

   assign prdata_out = rdata_q;
   assign pready_out = ready_q;
   assign pslverr_out = err_q;
   assign irq_out = irq_q;
   assign tx_req_out = tx_req_q;

   boff_sets_a: assert property (@(posedge clk_in) disable iff (rst_in)
      c.boff_evt |=> stat_q[cbs_pkg::IRQ_BOFF]) else $error("bus-off entry did not set flag");
   flag_w1c_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(stat_q[cbs_pkg::IRQ_BOFF]) |-> $past(w1c[cbs_pkg::IRQ_BOFF])) else $error("flag cleared without write");
   soft_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (rise[cbs_pkg::SYN_GSR] && !c.soft_busy && !c.guard) |=> c.soft_busy) else $error("global soft reset ignored");
   masked_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (!mask_q[cbs_pkg::IRQ_BOFF] && mask_q[2:1] == 2'b00) |=> !irq_out) else $error("masked flag raised irq");
   irq_follows_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (stat_q[cbs_pkg::IRQ_BOFF] && mask_q[cbs_pkg::IRQ_BOFF]) |=> irq_out) else $error("unmasked flag gave no irq");
endmodule : cbs_top
`default_nettype wire

// ===== src/cbs_pkg.sv
// constants, types and register map of the can bus-off / soft-reset / abort block
// assumes a 50 MHz peripheral clock and 32-bit apb access
`default_nettype none
package cbs_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;
   // register byte offsets
   localparam logic [7:0] OFF_MODCFG = 8'h00;
   localparam logic [7:0] OFF_ESR = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFF_TRANSMIT_MESSAGE_BUFFER = 8'h10;
   // field positions
   localparam int unsigned SOFT_RST_BIT = 0;
   localparam int unsigned FLT_LSB = 0;
   localparam int unsigned BOFF_FLAG_BIT = 2;
   localparam int unsigned TEC_LSB = 8;
   localparam int unsigned IRQ_BOFF = 0;
   localparam int unsigned IRQ_TXDONE = 1;
   localparam int unsigned IRQ_SRDONE = 2;
   localparam int unsigned NUM_IRQ = 3;
   localparam int unsigned TRANSMIT_MESSAGE_BUFFER_FLAG_BIT = 4;
   // reset values
   localparam logic [NUM_IRQ-1:0] IRQ_MASK_RST = 3'h0;
   // transmit buffer state codes
   localparam logic [3:0] CODE_INACTIVE = 4'h8;
   localparam logic [3:0] CODE_ABORT = 4'h9;
   localparam logic [3:0] CODE_DATA = 4'hc;
   // transmit error counter
   localparam int unsigned TEC_W = 9;
   localparam logic [TEC_W-1:0] TEC_ERR_INC = 9'h008;
   localparam logic [TEC_W-1:0] TEC_PASSIVE_LIM = 9'h080;
   localparam logic [TEC_W-1:0] TEC_BUSOFF_LIM = 9'h100;
   // timing
   localparam int unsigned SRST_TIME_NS = 100;
   localparam int unsigned SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GUARD_CLKS = 4;
   localparam int unsigned SR_CNT_W = 4;
   // synchronised engine and global soft-reset inputs
   localparam int unsigned SYN_ERR = 0;
   localparam int unsigned SYN_OK = 1;
   localparam int unsigned SYN_START = 2;
   localparam int unsigned SYN_WON = 3;
   localparam int unsigned SYN_GSR = 4;
   localparam int unsigned SYN_N = 5;
   typedef enum logic [1:0] {FC_ACTIVE = 2'b00, FC_PASSIVE = 2'b01, FC_BUSOFF = 2'b11} cbs_fc_t;
   typedef enum logic [1:0] {SR_IDLE = 2'b00, SR_RUN = 2'b01, SR_GUARD = 2'b11} cbs_sr_t;
endpackage : cbs_pkg
`default_nettype wire

// ===== src/cbs_ctl_if.sv
// signals between the register front end and its fault and transmit-buffer units
// assumes all parties on clk_in
`timescale 1ns/100ps
`default_nettype none
interface cbs_ctl_if;
   logic soft_req;
   logic soft_busy;
   logic sr_done;
   logic guard;
   logic err_evt;
   logic ok_evt;
   logic boff_evt;
   logic [1:0] flt;
   logic [cbs_pkg::TEC_W-1:0] tec;
   logic code_we;
   logic [3:0] code_wd;
   logic [3:0] code;
   logic start_evt;
   logic won_evt;
   logic done_evt;
   logic tx_req;
   modport fcs (input soft_req, err_evt, ok_evt, output soft_busy, sr_done, guard, boff_evt, flt, tec);
   modport txm (input code_we, code_wd, start_evt, won_evt, output code, done_evt, tx_req);
   modport top (output soft_req, err_evt, ok_evt, code_we, code_wd, start_evt, won_evt,
                input soft_busy, sr_done, guard, boff_evt, flt, tec, code, done_evt, tx_req);
endinterface : cbs_ctl_if
`default_nettype wire

// ===== src/cbs_fcs.sv
// fault confinement state, error counter and soft-reset sequencer
// assumes one-cycle error/success pulses already in the clk_in domain
`timescale 1ns/100ps
`default_nettype none
module cbs_fcs (
   input wire logic clk_in,  // peripheral clock
   input wire logic rst_in,  // async reset, high
   cbs_ctl_if.fcs c          // control carrier
);
   localparam int SR_MAX = cbs_pkg::SRST_CYCLES + 1;
   cbs_pkg::cbs_fc_t fc_q;
   cbs_pkg::cbs_sr_t sr_q;
   logic [cbs_pkg::SR_CNT_W-1:0] cnt_q;
   logic [cbs_pkg::TEC_W-1:0] tec_q;
   logic [cbs_pkg::TEC_W:0] tec_sum;

   assign tec_sum = {1'b0, tec_q} + {1'b0, cbs_pkg::TEC_ERR_INC};

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sr_q <= cbs_pkg::SR_IDLE;
         cnt_q <= 4'h0;
      end else begin
         case (sr_q)
            cbs_pkg::SR_IDLE: begin
               if (c.soft_req) begin
                  sr_q <= cbs_pkg::SR_RUN;
                  cnt_q <= 4'h0;
               end
            end
            cbs_pkg::SR_RUN: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == cbs_pkg::SR_CNT_W'(cbs_pkg::SRST_CYCLES - 1)) begin
                  sr_q <= cbs_pkg::SR_GUARD;
                  cnt_q <= 4'h0;
               end
            end
            cbs_pkg::SR_GUARD: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == cbs_pkg::SR_CNT_W'(cbs_pkg::GUARD_CLKS - 1)) begin
                  sr_q <= cbs_pkg::SR_IDLE;
               end
            end
            default: sr_q <= cbs_pkg::SR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tec_q <= '0;
      end else if (sr_q == cbs_pkg::SR_RUN) begin
         tec_q <= '0;
      end else if (fc_q != cbs_pkg::FC_BUSOFF) begin
         if (c.err_evt) begin
            tec_q <= tec_sum[cbs_pkg::TEC_W] ? '1 : tec_sum[cbs_pkg::TEC_W-1:0];
         end else if (c.ok_evt && tec_q != '0) begin
            tec_q <= tec_q - 9'h001;
         end
      end
   end

   // bus-off sticks until a soft reset; no re-entry during the guard window
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fc_q <= cbs_pkg::FC_ACTIVE;
      end else if (sr_q != cbs_pkg::SR_IDLE || c.soft_req) begin
         // leave bus-off on the request edge itself, so it never shows during the reset
         fc_q <= cbs_pkg::FC_ACTIVE;
      end else if (fc_q != cbs_pkg::FC_BUSOFF) begin
         if (tec_q >= cbs_pkg::TEC_BUSOFF_LIM) fc_q <= cbs_pkg::FC_BUSOFF;
         else if (tec_q >= cbs_pkg::TEC_PASSIVE_LIM) fc_q <= cbs_pkg::FC_PASSIVE;
         else fc_q <= cbs_pkg::FC_ACTIVE;
      end
   end

   assign c.flt = fc_q;
   assign c.tec = tec_q;
   assign c.soft_busy = (sr_q == cbs_pkg::SR_RUN);
   assign c.guard = (sr_q == cbs_pkg::SR_GUARD);
   assign c.sr_done = (sr_q == cbs_pkg::SR_RUN) && (cnt_q == cbs_pkg::SR_CNT_W'(cbs_pkg::SRST_CYCLES - 1));
   assign c.boff_evt = (sr_q == cbs_pkg::SR_IDLE) && (fc_q != cbs_pkg::FC_BUSOFF)
                       && (tec_q >= cbs_pkg::TEC_BUSOFF_LIM);

   busy_clears_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(c.soft_busy) |-> ##[1:SR_MAX] !c.soft_busy) else $error("soft reset bit never self-clears");
   sr_active_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (c.soft_busy || c.guard) |-> c.flt == 2'b00) else $error("state not active in soft reset");
   guard_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (c.guard || c.soft_busy) |-> !c.boff_evt && c.flt != 2'b11) else $error("bus-off shown after soft reset");
endmodule : cbs_fcs
`default_nettype wire

// ===== src/cbs_transmit_message_buffer.sv
// one transmit message buffer: state code, abort blocking, completion
// assumes start/won pulses from the protocol engine already in clk_in domain
`timescale 1ns/100ps
`default_nettype none
module cbs_transmit_message_buffer (
   input wire logic clk_in,  // peripheral clock
   input wire logic rst_in,  // async reset, high
   cbs_ctl_if.txm c          // control carrier
);
   logic [3:0] code_q;
   logic sent_q;
   logic active;

   assign active = (code_q == cbs_pkg::CODE_DATA) || (code_q == cbs_pkg::CODE_ABORT);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sent_q <= 1'b0;
      end else if (c.won_evt) begin
         sent_q <= 1'b0;
      end else if (c.start_evt && active) begin
         sent_q <= 1'b1;  // engine latched this buffer for arbitration
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         code_q <= cbs_pkg::CODE_INACTIVE;
      end else if (c.won_evt && sent_q && active) begin
         code_q <= cbs_pkg::CODE_INACTIVE;
      end else if (c.code_we && code_q != cbs_pkg::CODE_ABORT) begin
         code_q <= c.code_wd;
      end
   end

   // a deactivated buffer may still go out: no flag, no state change
   assign c.done_evt = c.won_evt && sent_q && active;
   assign c.code = code_q;
   assign c.tx_req = active;

   abort_blocks_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (c.code == cbs_pkg::CODE_ABORT && !c.won_evt) |=> c.code == cbs_pkg::CODE_ABORT)
      else $error("abort pending buffer code changed");
   deact_silent_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (c.won_evt && c.code == cbs_pkg::CODE_INACTIVE) |-> !c.done_evt ##1 c.code == cbs_pkg::CODE_INACTIVE)
      else $error("deactivated buffer reported completion");
endmodule : cbs_transmit_message_buffer
`default_nettype wire

// ===== test/cbs_node_model.sv
// far side: other can nodes, seen as protocol-engine event pins
// assumes one event requested at a time, all on clk_in
`timescale 1ns/100ps
`default_nettype none
module cbs_node_model (
   input wire logic clk_in,        // peripheral clock
   input wire logic rst_in,        // async reset, high
   input wire logic go_in,         // start one event
   input wire logic slow_in,       // hold the pin longer
   input wire logic [2:0] kind_in, // 0 err 1 ok 2 start 3 won 4 global reset
   output logic idle_out,          // ready for the next event
   output logic [4:0] ev_out       // event pins
);
   logic [3:0] cnt_q;
   assign idle_out = (cnt_q == 4'h0);
   // pin high 2 or 7 clocks, then low at least 3
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= 4'h0;
         ev_out <= 5'h00;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h3) begin
            ev_out <= 5'h00;
         end
      end else if (go_in) begin
         ev_out <= 5'h01 << kind_in;
         cnt_q <= slow_in ? 4'h9 : 4'h4;
      end
   end
endmodule : cbs_node_model
`default_nettype wire

// ===== test/can_busoff_softreset_abort_bench.sv
// self-checking bench: bus-off flag, soft reset, transmit buffer abort
// assumes cbs_pkg, cbs_top and cbs_node_model are compiled before it
`timescale 1ns/100ps
`default_nettype none
module can_busoff_softreset_abort_bench;
   logic clk_in, rst_in, psel, penable, pwrite, pready, pslverr, tx_req, irq, go, slow, idle;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [2:0] kind;
   logic [4:0] ev;
   int errors, checked, seed, nok, g, c, n;

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   cbs_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .tx_err_in(ev[0]), .tx_ok_in(ev[1]),
      .tx_start_in(ev[2]), .tx_won_in(ev[3]), .glb_soft_rst_in(ev[4]), .tx_req_out(tx_req),
      .irq_out(irq));
   cbs_node_model node_u (.clk_in(clk_in), .rst_in(rst_in), .go_in(go), .slow_in(slow),
      .kind_in(kind), .idle_out(idle), .ev_out(ev));

   task automatic end_of_test;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // expected error and status word from state, flag and error count
   function automatic logic [31:0] esr_exp(input logic [1:0] flt, input logic flag, input int tec);
      esr_exp = 32'(tec) << cbs_pkg::TEC_LSB;
      esr_exp[cbs_pkg::FLT_LSB +: 2] = flt;
      esr_exp[cbs_pkg::BOFF_FLAG_BIT] = flag;
   endfunction : esr_exp

   task automatic hang;
      errors++;
      end_of_test();
   endtask : hang

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd_d);
      int k;
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_in);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) hang();
      rd_d = pslverr ? 32'hffff_ffff : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      apb(1'b1, a, v, x);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      apb(1'b0, a, $random(seed), v);
   endtask : rd

   // one engine event through the far-side model
   task automatic ev_do(input logic [2:0] k);
      int i;
      logic [31:0] r;
      r = $random(seed);
      @(posedge clk_in);
      go <= 1'b1;
      kind <= k;
      slow <= r[0];
      @(posedge clk_in);
      go <= 1'b0;
      i = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (idle !== 1'b1 && i < 20);
      if (i >= 20) hang();
   endtask : ev_do

   initial begin
      errors = 0;
      checked = 0;
      seed = 32'h9902;
      rst_in = 1'b1;
      {psel, penable, pwrite, go, slow} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      kind = 3'h0;
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(cbs_pkg::OFF_MODCFG, d); chk("modcfg", d, 32'h0);
      rd(cbs_pkg::OFF_ESR, d); chk("esr", d, 32'h0);
      rd(cbs_pkg::OFF_IRQ_MASK, d); chk("mask", d, 32'h0);
      rd(cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER, d); chk("transmit_message_buffer", d, 32'h8);
      wr(8'h14, 32'h1);
      rd(8'h14, d); chk("unmapped", d, 32'hffff_ffff);
      // passive, back to active, then bus-off with the mask clear
      repeat (16) ev_do(3'd0);
      rd(cbs_pkg::OFF_ESR, d); chk("passive", d, esr_exp(2'b01, 1'b0, 128));
      nok = 1 + ($unsigned($random(seed)) % 4);
      repeat (nok) ev_do(3'd1);
      rd(cbs_pkg::OFF_ESR, d); chk("active", d, esr_exp(2'b00, 1'b0, 128 - nok));
      repeat ((128 + nok + 7) / 8) ev_do(3'd0);
      rd(cbs_pkg::OFF_ESR, d); chk("busoff", d & 32'h7, 32'h7);
      rd(cbs_pkg::OFF_IRQ_STAT, d); chk("stat", d & 32'h1, 32'h1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(cbs_pkg::OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk_in);
      chk("irq on", {31'h0, irq}, 32'h1);
      wr(cbs_pkg::OFF_ESR, 32'h0);
      rd(cbs_pkg::OFF_ESR, d); chk("flag kept", d & 32'h4, 32'h4);
      wr(cbs_pkg::OFF_ESR, 32'h4);
      repeat (2) @(posedge clk_in);
      chk("irq off", {31'h0, irq}, 32'h0);
      // soft reset by config bit, then by global request
      for (g = 0; g < 2; g++) begin
         if (g == 1) begin
            repeat (32) ev_do(3'd0);
            rd(cbs_pkg::OFF_ESR, d); chk("busoff again", d & 32'h7, 32'h7);
            chk("irq again", {31'h0, irq}, 32'h1);
            wr(cbs_pkg::OFF_ESR, 32'h4);
         end
         wr(cbs_pkg::OFF_IRQ_MASK, 32'h0);
         if (g == 0) wr(cbs_pkg::OFF_MODCFG, 32'h1);
         else ev_do(3'd4);
         n = 0;
         do begin
            rd(cbs_pkg::OFF_MODCFG, d);
            n++;
         end while (d[0] !== 1'b0 && n < 20);
         chk("srst ack", d, 32'h0);
         repeat (4) @(posedge clk_in);
         n = 0;
         do begin
            rd(cbs_pkg::OFF_ESR, d);
            chk("no flag", d & 32'h4, 32'h0);
            n++;
         end while (d[1:0] !== 2'b00 && n < 20);
         chk("flt", d & 32'h3, 32'h0);
         rd(cbs_pkg::OFF_IRQ_STAT, d); chk("srdone", d & 32'h5, 32'h4);
         wr(cbs_pkg::OFF_ESR, 32'h4);
         wr(cbs_pkg::OFF_IRQ_MASK, 32'h1);
         repeat (8) @(posedge clk_in);
         chk("irq quiet", {31'h0, irq}, 32'h0);
         wr(cbs_pkg::OFF_IRQ_STAT, 32'h7);
      end
      // buffer: plain send, abort, deactivate in flight
      for (c = 0; c < 3; c++) begin
         wr(cbs_pkg::OFF_IRQ_STAT, 32'h7);
         wr(cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER, 32'h1c);
         if (c == 1) begin
            wr(cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER, 32'h9);
            wr(cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER, 32'h8);
            rd(cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER, d); chk("abort blocks", d, 32'h9);
         end
         ev_do(3'd2);
         chk("txreq", {31'h0, tx_req}, 32'h1);
         if (c == 2) wr(cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER, 32'h8);
         ev_do(3'd3);
         rd(cbs_pkg::OFF_TRANSMIT_MESSAGE_BUFFER, d); chk("code", d, (c == 2) ? 32'h8 : 32'h18);
         rd(cbs_pkg::OFF_IRQ_STAT, d); chk("txdone", d & 32'h2, (c == 2) ? 32'h0 : 32'h2);
         chk("txreq off", {31'h0, tx_req}, 32'h0);
      end
      end_of_test();
   end
endmodule : can_busoff_softreset_abort_bench
`default_nettype wire
